// ### fbsc_top.sv
// module: flash boot select, overlay, vpp and idle control
`timescale 1ns/10ps
module fbsc_top #(
   parameter int unsigned VPP_CYCLES  = fbsc_pkg::VPP_CYC,
   parameter int unsigned WAKE_CYCLES = fbsc_pkg::WAKE_CYC
) (
   // clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  arst_n_in,
   // reset-time strap pins
   input  wire logic                  fetch_strobe_n_in,
   input  wire logic                  ale_in,
   input  wire logic                  ext_access_n_in,
   input  wire logic                  vpp_tied_vdd_in,
   // software control bits
   input  wire logic                  boot_rom_enable_wr_in,
   input  wire logic                  boot_rom_enable_in,
   input  wire logic                  flash_idle_enable_wr_in,
   input  wire logic                  flash_idle_enable_in,
   input  wire logic                  cpu_idle_in,
   // flash operation requests
   input  wire logic                  req_valid_in,
   input  wire fbsc_pkg::fbsc_req_t   req_in,
   input  wire logic                  prog_fail_in,
   // instruction fetch decode
   input  wire logic [15:0]           fetch_addr_in,
   // status outputs
   output logic                       boot_rom_enable_out,
   output logic                       prog_voltage_valid_out,
   output logic                       flash_idle_enable_out,
   output logic                       vpp_gen_on_out,
   output logic                       flash_power_down_out,
   output logic                       cpu_hold_out,
   output logic                       vector_ready_out,
   output fbsc_pkg::fbsc_vector_t     reset_vector_out,
   output logic [7:0]                 status_byte_out,
   output fbsc_pkg::fbsc_vector_t     boot_vector_out,
   output fbsc_pkg::fbsc_fetch_t      fetch_route_out,
   // flash array commands
   output logic                       flash_wr_out,
   output logic [15:0]                flash_addr_out,
   output logic [7:0]                 flash_data_out,
   output logic [fbsc_pkg::NUM_BLOCKS-1:0] flash_erase_out
);
   // ---------------------------------------------------------------
   // parameter range checks
   // ---------------------------------------------------------------
   // both delays run in CNT_W bit counters; zero would give no delay at all
   localparam int unsigned CNT_MAX = (1 << fbsc_pkg::CNT_W) - 1;
   if (VPP_CYCLES < 1 || VPP_CYCLES > CNT_MAX) begin : g_vpp_chk
      $error("VPP_CYCLES out of range");
   end
   if (WAKE_CYCLES < 1 || WAKE_CYCLES > CNT_MAX) begin : g_wake_chk
      $error("WAKE_CYCLES out of range");
   end

   localparam logic [9:0]  VPP_LIM     = 10'(VPP_CYCLES);
   localparam logic [9:0]  WAKE_LIM    = 10'(WAKE_CYCLES);
   // a byte program to this address lands in the status byte
   localparam logic [15:0] STATUS_ADDR = 16'hFFFF;

   // ---------------------------------------------------------------
   // strap synchronisers and reset release capture
   // ---------------------------------------------------------------
   logic [2:0] strap_s1;
   logic [2:0] strap_s2;
   logic       vpp_s1;
   logic       vpp_s2;
   logic       first;

   // straps keep sampling through reset, so the first edge after
   // release sees the level the board held while reset was low
   always_ff @(posedge sys_clk_in) begin
      strap_s1 <= {fetch_strobe_n_in, ale_in, ext_access_n_in};
      strap_s2 <= strap_s1;
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vpp_s1 <= 1'b0;
         vpp_s2 <= 1'b0;
      end else begin
         vpp_s1 <= vpp_tied_vdd_in;
         vpp_s2 <= vpp_s1;
      end
   end

   // straps as seen through reset; board must hold them until release
   wire strap_force = !strap_s2[2] && strap_s2[1] && strap_s2[0];
   wire status_nz   = (status_byte_out != fbsc_pkg::STATUS_ERASED);
   wire boot_sel    = status_nz || strap_force;

   // ---------------------------------------------------------------
   // flash operation request decode
   // ---------------------------------------------------------------
   wire              req_go  = req_valid_in && first;
   wire              op_prog = req_go && req_in.op == fbsc_pkg::FBSC_OP_PROG;
   wire              op_blk  = req_go && req_in.op == fbsc_pkg::FBSC_OP_BLK;
   wire              op_chip = req_go && req_in.op == fbsc_pkg::FBSC_OP_CHIP;
   wire              op_vect = req_go && req_in.op == fbsc_pkg::FBSC_OP_VECT;
   wire [1:0]        vsel    = req_in.addr[1:0];
   wire [7:0]        wdata   = req_in.data;

   // ---------------------------------------------------------------
   // flash block decode
   // ---------------------------------------------------------------
   function automatic logic [2:0] blk_of(input logic [15:0] a);
      logic [2:0] b;
      b = 3'h4;
      if (a < fbsc_pkg::BLK1_BASE)      b = 3'h0;
      else if (a < fbsc_pkg::BLK2_BASE) b = 3'h1;
      else if (a < fbsc_pkg::BLK3_BASE) b = 3'h2;
      else if (a < fbsc_pkg::BLK4_BASE) b = 3'h3;
      return b;
   endfunction

   wire [2:0] req_blk   = blk_of(req_in.addr);
   wire [2:0] fetch_blk = blk_of(fetch_addr_in);
   wire       in_top    = fetch_addr_in >= fbsc_pkg::BOOT_ROM_BASE;
   wire       rom_hit   = in_top && boot_rom_enable_out;

   logic [fbsc_pkg::NUM_BLOCKS-1:0] next_erase;
   genvar gi;
   generate
      for (gi = 0; gi < fbsc_pkg::NUM_BLOCKS; gi++) begin : g_erase
         assign next_erase[gi] = op_chip ||
                                 (op_blk && req_blk == 3'(gi));
      end
   endgenerate

   // ---------------------------------------------------------------
   // status byte and boot vector cells
   // ---------------------------------------------------------------
   // cells keep their contents through reset; the start value is the
   // image of a factory fresh part
   logic [7:0]             status_nv = fbsc_pkg::STATUS_ERR;
   fbsc_pkg::fbsc_vector_t vector_nv = '{pc:  fbsc_pkg::FACT_BPC,
                                         psw: fbsc_pkg::FACT_BOOT_STATUS_WORD};
   wire                    vect_erase = op_vect &&
                                        wdata == fbsc_pkg::BYTE_ERASED;
   wire                    status_wr  = op_prog &&
                                        req_in.addr == STATUS_ADDR;

   // an error report wins over an erase or write in the same cycle
   always_ff @(posedge sys_clk_in) begin
      if (prog_fail_in) begin
         status_nv <= fbsc_pkg::STATUS_ERR;
      end else if (vect_erase) begin
         status_nv <= fbsc_pkg::STATUS_ERASED;
         vector_nv <= '1;
      end else if (op_vect) begin
         unique case (vsel)
            2'h0: vector_nv.pc[7:0]   <= wdata;
            2'h1: vector_nv.pc[15:8]  <= wdata;
            2'h2: vector_nv.psw[7:0]  <= wdata;
            2'h3: vector_nv.psw[15:8] <= wdata;
         endcase
      end else if (status_wr) begin
         status_nv <= wdata;
      end
   end

   assign status_byte_out = status_nv;
   assign boot_vector_out = vector_nv;

   // ---------------------------------------------------------------
   // boot enable, vector ready, reset vector
   // ---------------------------------------------------------------
   logic [9:0] vpp_cnt;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         first                  <= 1'b0;
         boot_rom_enable_out    <= 1'b0;
         vector_ready_out       <= 1'b0;
         reset_vector_out       <= '0;
      end else if (!first) begin
         first                  <= 1'b1;
         boot_rom_enable_out    <= boot_sel;
         vector_ready_out       <= 1'b1;
         reset_vector_out       <= boot_sel ? boot_vector_out
            : '{pc: fbsc_pkg::APP_START, psw: 16'h0000};
      end else if (boot_rom_enable_wr_in) begin
         boot_rom_enable_out    <= boot_rom_enable_in;
      end
   end

   // ---------------------------------------------------------------
   // programming voltage generator
   // ---------------------------------------------------------------
   // generator runs only when the supply pin sits on the logic rail
   wire       next_vpp_on  = boot_rom_enable_out && vpp_s2;
   wire       vpp_done     = vpp_cnt == VPP_LIM;
   wire [9:0] next_vpp_cnt = !boot_rom_enable_out ? 10'h000 :
                             vpp_done ? vpp_cnt : vpp_cnt + 10'h001;
   // only boot enable and the vpp_cnt delay drive it, not vpp_s2; no write path exists
   wire       next_valid   = boot_rom_enable_out && vpp_done;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vpp_gen_on_out         <= 1'b0;
         vpp_cnt                <= 10'h000;
         prog_voltage_valid_out <= 1'b0;
      end else begin
         vpp_gen_on_out         <= next_vpp_on;
         vpp_cnt                <= next_vpp_cnt;
         prog_voltage_valid_out <= next_valid;
      end
   end

   // ---------------------------------------------------------------
   // flash idle and wake delay
   // ---------------------------------------------------------------
   logic [9:0] wake_cnt;
   wire        idle_pd       = flash_idle_enable_out && cpu_idle_in;
   wire        wake_busy     = wake_cnt != 10'h000;
   // the array needs time to restart after an idle with it switched off
   wire [9:0]  next_wake_cnt = idle_pd ? WAKE_LIM :
                               wake_busy ? wake_cnt - 10'h001 : wake_cnt;
   wire        next_cpu_hold = idle_pd || wake_cnt > 10'h001;
   wire        next_idle_en  = flash_idle_enable_wr_in ?
                               flash_idle_enable_in : flash_idle_enable_out;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flash_idle_enable_out <= 1'b0;
         flash_power_down_out  <= 1'b0;
         wake_cnt              <= 10'h000;
         cpu_hold_out          <= 1'b0;
      end else begin
         flash_idle_enable_out <= next_idle_en;
         flash_power_down_out  <= idle_pd;
         wake_cnt              <= next_wake_cnt;
         cpu_hold_out          <= next_cpu_hold;
      end
   end

   // ---------------------------------------------------------------
   // fetch routing and flash command register
   // ---------------------------------------------------------------
   fbsc_pkg::fbsc_fetch_t next_route;
   assign next_route = '{to_boot_rom: rom_hit, to_flash: !rom_hit,
                         block: fetch_blk};

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fetch_route_out <= '0;
         flash_wr_out    <= 1'b0;
         flash_addr_out  <= 16'h0000;
         flash_data_out  <= 8'h00;
         flash_erase_out <= '0;
      end else begin
         fetch_route_out <= next_route;
         flash_wr_out    <= op_prog;
         flash_addr_out  <= req_in.addr;
         flash_data_out  <= wdata;
         flash_erase_out <= next_erase;
      end
   end
endmodule

// ### fbsc_pkg.sv
// package: constants and carrier types for the flash boot select control
package fbsc_pkg;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned NUM_BLOCKS   = 5;
   localparam int unsigned BLK_W        = 3;
   localparam logic [15:0] BLK1_BASE    = 16'h2000;
   localparam logic [15:0] BLK2_BASE    = 16'h4000;
   localparam logic [15:0] BLK3_BASE    = 16'h8000;
   localparam logic [15:0] BLK4_BASE    = 16'hC000;
   localparam logic [15:0] BOOT_ROM_BASE = 16'hF800;
   localparam logic [15:0] APP_START    = 16'h0000;
   localparam logic [15:0] FACT_BPC     = 16'hF800;
   localparam logic [15:0] FACT_BOOT_STATUS_WORD    = 16'h8000;
   localparam logic [7:0]  STATUS_ERASED = 8'h00;
   localparam logic [7:0]  STATUS_ERR   = 8'h01;
   localparam logic [7:0]  BYTE_ERASED  = 8'hFF;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned VPP_NS       = 5000;
   localparam int unsigned WAKE_NS      = 3000;
   localparam int unsigned VPP_CYC      = (VPP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CYC     = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W        = 10;

   typedef enum logic [2:0] {
      FBSC_OP_NONE  = 3'h0,
      FBSC_OP_PROG  = 3'h1,
      FBSC_OP_BLK   = 3'h2,
      FBSC_OP_CHIP  = 3'h3,
      FBSC_OP_VECT  = 3'h4
   } fbsc_op_t;

   typedef struct packed {
      fbsc_op_t    op;
      logic [15:0] addr;
      logic [7:0]  data;
   } fbsc_req_t;

   typedef struct packed {
      logic        to_boot_rom;
      logic        to_flash;
      logic [2:0]  block;
   } fbsc_fetch_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] psw;
   } fbsc_vector_t;
endpackage

// ### fbsc_properties.sv
// assertion checker on the flash boot select control ports
`timescale 1ns/10ps
module fbsc_properties #(
   parameter int unsigned VPP_CYCLES = 4
) (
   input wire logic                   sys_clk_in, arst_n_in, vpp_tied_vdd_in,
   input wire logic                   cpu_idle_in, req_valid_in, prog_fail_in,
   input wire fbsc_pkg::fbsc_req_t    req_in,
   input wire logic [15:0]            fetch_addr_in, flash_addr_out,
   input wire logic                   boot_rom_enable_out, vector_ready_out,
   input wire logic                   prog_voltage_valid_out, cpu_hold_out,
   input wire logic                   flash_idle_enable_out, flash_wr_out,
   input wire logic                   flash_power_down_out, vpp_gen_on_out,
   input wire logic [7:0]             flash_data_out, status_byte_out,
   input wire logic [4:0]             flash_erase_out,
   input wire fbsc_pkg::fbsc_fetch_t  fetch_route_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire take = req_valid_in && vector_ready_out;
   wire top = fetch_addr_in >= 16'hF800;
   int unsigned on_cnt;
   // cycles the generator has been asked to run
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
      if (!arst_n_in) on_cnt <= 0;
      else on_cnt <= (boot_rom_enable_out && vpp_tied_vdd_in) ? on_cnt + 1 : 0;
   sequence s_wake;
      ##[0:2] cpu_hold_out ##[1:40] !cpu_hold_out;
   endsequence
   AST_PROG: assert property (take && req_in.op == fbsc_pkg::FBSC_OP_PROG
      && req_in.addr != 16'hFFFF |=> flash_wr_out && flash_addr_out ==
      $past(req_in.addr) && flash_data_out == $past(req_in.data))
      else $error("program byte not issued");
   AST_CHIP: assert property (take && req_in.op == fbsc_pkg::FBSC_OP_CHIP
      |=> flash_erase_out == 5'h1F) else $error("chip erase mask wrong");
   AST_BLK: assert property (take && req_in.op == fbsc_pkg::FBSC_OP_BLK
      |=> $onehot(flash_erase_out)) else $error("block erase not one block");
   AST_ROM: assert property ((boot_rom_enable_out && top)[*2]
      |=> fetch_route_out.to_boot_rom) else $error("overlay not decoded");
   AST_TOP: assert property ((!boot_rom_enable_out && top)[*2] |=>
      fetch_route_out.to_flash && fetch_route_out.block == 3'h4)
      else $error("top flash not reachable");
   AST_VPP: assert property (on_cnt > VPP_CYCLES + 3 |->
      vpp_gen_on_out && prog_voltage_valid_out) else $error("vpp late");
   AST_PDOWN: assert property (flash_idle_enable_out && cpu_idle_in |=>
      flash_power_down_out) else $error("flash not powered down");
   AST_WAKE: assert property ($fell(cpu_idle_in) && flash_power_down_out
      |-> s_wake) else $error("wake delay wrong");
   AST_FAIL: assert property (prog_fail_in |=> status_byte_out != 8'h00)
      else $error("status not set on error");
   AST_VEC: assert property (take && !prog_fail_in && req_in.op ==
      fbsc_pkg::FBSC_OP_VECT && req_in.data == 8'hFF |=>
      status_byte_out == 8'h00) else $error("status not erased");
endmodule
bind fbsc_top fbsc_properties #(.VPP_CYCLES(VPP_CYCLES)) u_props (.*);

// ### fbsc_board.sv
// board strap pins around the block, held through reset
`timescale 1ns/10ps
module fbsc_board (
   // clock, reset and strap choice
   input  wire logic sys_clk_in,
   input  wire logic arst_n_in,
   input  wire logic force_boot_in,
   // strap pins
   output logic      fetch_strobe_n_out,
   output logic      ale_out,
   output logic      ext_access_n_out
);
   logic       tgl  = 1'b0;
   logic [1:0] held = 2'h0;
   wire        bus  = held == 2'h3;
   // straps stay put a few edges past release, then bus traffic
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
      if (!arst_n_in) held <= 2'h0;
      else if (!bus) held <= held + 2'h1;
   always_ff @(posedge sys_clk_in) tgl <= !tgl;
   assign fetch_strobe_n_out = bus ? tgl : !force_boot_in;
   assign ale_out            = bus ? !tgl : 1'b1;
   assign ext_access_n_out   = bus ? tgl : force_boot_in;
endmodule

// ### tb_top.sv
// self-checking bench for the flash boot select control
`timescale 1ns/10ps
module tb_top;
   logic sys_clk_in = 1'b0, arst_n_in = 1'b0, vpp_tied_vdd_in = 1'b1;
   logic boot_rom_enable_wr_in = 1'b0, boot_rom_enable_in = 1'b0;
   logic flash_idle_enable_wr_in = 1'b0, flash_idle_enable_in = 1'b0;
   logic cpu_idle_in = 1'b0, req_valid_in = 1'b0, prog_fail_in = 1'b0;
   logic fetch_strobe_n_in, ale_in, ext_access_n_in, force_boot = 1'b0;
   fbsc_pkg::fbsc_req_t req_in = '0;
   logic [15:0] fetch_addr_in = 16'h0000, flash_addr_out, a;
   logic boot_rom_enable_out, prog_voltage_valid_out, flash_idle_enable_out;
   logic vpp_gen_on_out, flash_power_down_out, cpu_hold_out, flash_wr_out;
   logic vector_ready_out;
   logic [7:0] status_byte_out, flash_data_out;
   logic [4:0] flash_erase_out, r;
   logic [31:0] d;
   fbsc_pkg::fbsc_vector_t reset_vector_out, boot_vector_out;
   fbsc_pkg::fbsc_fetch_t fetch_route_out;
   logic [15:0] edges [12] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h3FFF,
      16'h4000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hF7FF, 16'hF800,
      16'hFFFF};
   int n_mismatch = 0, num_checks = 0, seed = 25134, i, k, m_be;
   always #5 sys_clk_in = !sys_clk_in;
   fbsc_board u_fbsc_board (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .force_boot_in(force_boot), .fetch_strobe_n_out(fetch_strobe_n_in),
      .ale_out(ale_in), .ext_access_n_out(ext_access_n_in));
   fbsc_top #(.VPP_CYCLES(4), .WAKE_CYCLES(3)) u_fbsc_top (.*);
   // ----------------------------------------
   // model and helpers
   // ----------------------------------------
   function automatic logic [4:0] route_of(int x, int be);
      if (be != 0 && x >= 16'hF800) return 5'h10;
      if (x < 16'h2000) return 5'h08;
      if (x < 16'h4000) return 5'h09;
      return {2'b01, 3'(x / 16'h4000 + 1)};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic wt(ref logic s, input logic v, output int n);
      for (n = 0; s !== v; n++) begin
         if (n == 50) begin
            n_mismatch++;
            results;
         end
         cyc(1);
      end
   endtask
   task automatic rst(input logic f);
      force_boot <= f;
      arst_n_in <= 1'b0;
      repeat (12) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      cyc(2);
   endtask
   task automatic send(input fbsc_pkg::fbsc_op_t op, input logic [15:0] ad,
                       input logic [7:0] dt, input bit last);
      req_valid_in <= 1'b1;
      req_in <= '{op, ad, dt};
      cyc(1);
      if (last) req_valid_in <= 1'b0;
   endtask
   task automatic set_be(input logic v);
      boot_rom_enable_wr_in <= 1'b1;
      boot_rom_enable_in <= v;
      cyc(1);
      boot_rom_enable_wr_in <= 1'b0;
      cyc(1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      rst(1'b0);
      chk("boot_en", 1, boot_rom_enable_out);
      chk("rst_vec", 32'hF8008000, reset_vector_out);
      chk("boot_vec", 32'hF8008000, boot_vector_out);
      chk("vec_ready", 1, vector_ready_out);
      wt(prog_voltage_valid_out, 1'b1, k);
      chk("vpp_on", 1, vpp_gen_on_out);
      for (m_be = 1; m_be >= 0; m_be--) begin
         set_be(m_be[0]);
         for (i = 0; i < 40; i++) begin
            a = i < 12 ? edges[i] : 16'($random(seed));
            fetch_addr_in <= a;
            cyc(2);
            r = route_of(a, m_be);
            chk("route", r, r[4] ? {fetch_route_out[4:3], 3'h0} : fetch_route_out);
         end
      end
      chk("valid_off", 0, prog_voltage_valid_out);
      set_be(1'b1);
      wt(prog_voltage_valid_out, 1'b1, k);
      chk("vpp_time", 1, k >= 2 && k <= 7);
      d = $random(seed);
      send(fbsc_pkg::FBSC_OP_PROG, d[31:16] & 16'hFFFE, d[7:0], 1'b0);
      chk("wr", {1'b1, d[31:16] & 16'hFFFE, d[7:0]}, {flash_wr_out, flash_addr_out, flash_data_out});
      for (i = 0; i < 5; i++) begin
         send(fbsc_pkg::FBSC_OP_BLK, edges[2*i], 8'h00, 1'b0);
         chk("blk_erase", 1 << i, flash_erase_out);
      end
      send(fbsc_pkg::FBSC_OP_CHIP, 16'h0000, 8'h00, 1'b0);
      chk("chip_erase", 5'h1F, flash_erase_out);
      d = $random(seed) & 32'h7F7F7F7F;
      for (i = 0; i < 4; i++)
         send(fbsc_pkg::FBSC_OP_VECT, 16'(i), d[8*i+:8], i == 3);
      cyc(1);
      chk("vec_wr", {d[15:0], d[31:16]}, boot_vector_out);
      send(fbsc_pkg::FBSC_OP_VECT, 16'h0000, 8'hFF, 1'b1);
      chk("status_erase", 8'h00, status_byte_out);
      chk("vec_erase", 32'hFFFFFFFF, boot_vector_out);
      prog_fail_in <= 1'b1;
      cyc(1);
      prog_fail_in <= 1'b0;
      chk("fail", 1, status_byte_out != 8'h00);
      flash_idle_enable_wr_in <= 1'b1;
      flash_idle_enable_in <= 1'b1;
      cyc(1);
      flash_idle_enable_wr_in <= 1'b0;
      cpu_idle_in <= 1'b1;
      cyc(2);
      chk("pdown", 1, flash_power_down_out & flash_idle_enable_out);
      cpu_idle_in <= 1'b0;
      cyc(1);
      wt(cpu_hold_out, 1'b0, k);
      chk("wake", 1, k <= 6);
      send(fbsc_pkg::FBSC_OP_VECT, 16'h0000, 8'hFF, 1'b1);
      rst(1'b0);
      chk("app_boot", 0, boot_rom_enable_out);
      chk("app_vec", 32'h00000000, reset_vector_out);
      rst(1'b1);
      chk("strap_boot", 1, boot_rom_enable_out);
      chk("strap_vec", 32'hFFFFFFFF, reset_vector_out);
      results;
   end
endmodule
